// [verilog/lsbx_core.sv]
/*
 * Execution unit for relative branches on T clear, V and I and the data
 * transfer group, with its own working registers, PC and stack pointer.
 * Assumes data, program and I/O memories answer combinationally in the
 * cycle their read strobe is high, and the status byte is read only.
 */
`timescale 1ns/1ps
`include "lsbx_consts.svh"

module lsbx_core
    import lsbx_pkg::*;
#(
    parameter logic [15:0] PC_RESET = `LSBX_PC_RESET,
    parameter logic [15:0] SP_RESET = `LSBX_SP_RESET
)(
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic             instr_valid,
    input  wire logic [15:0]      instr,
    input  wire logic [15:0]      instr_ext,
    input  wire logic [7:0]       sreg,
    input  wire logic [7:0]       dm_rdata,
    input  wire logic [15:0]      pm_rdata,
    input  wire logic [7:0]       io_rdata,
    output logic                  instr_ready,
    output logic                  done,
    output logic                  illegal,
    output logic [15:0]           pc,
    output logic [15:0]           sp,
    output logic [31:0][7:0]      regs,
    output lsbx_dm_req_t          dm,
    output lsbx_pm_req_t          pm,
    output lsbx_io_req_t          io
);

    lsbx_core_st_t    s_r;
    lsbx_core_st_t    s_nxt;
    logic [31:0][7:0] rfv;
    lsbx_agu_t        agu;
    logic [15:0]      koff;
    logic [3:0]       mode;
    logic [4:0]       fd;
    logic [4:0]       fr;
    logic [2:0]       bsel;
    logic             acc;
    logic             is_br;
    logic             br_ok;
    logic             br_taken;
    logic             is_ldst;
    logic             is_store;
    logic             ldst_ok;
    logic             is_disp;
    logic             is_pmr0;
    logic             is_pmw;
    logic             is_bset;
    logic             is_in;
    logic             is_out;
    logic             is_copy;
    logic             is_pcopy;
    logic             is_imm;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    assign acc      = instr_valid && s_r.ready;
    assign mode     = instr[3:0];
    assign fd       = instr[8:4];
    assign fr       = {instr[9], instr[3:0]};
    assign bsel     = instr[2:0];
    assign koff     = {{9{instr[9]}}, instr[9:3]};
    assign is_copy  = (instr & `LSBX_M_COPY) == `LSBX_V_COPY;
    assign is_pcopy = (instr & `LSBX_M_PCOPY) == `LSBX_V_PCOPY;
    assign is_imm   = (instr & `LSBX_M_IMM) == `LSBX_V_IMM;
    assign is_ldst  = (instr & `LSBX_M_LDST) == `LSBX_V_LDST;
    assign is_disp  = (instr & `LSBX_M_DISP) == `LSBX_V_DISP;
    assign is_pmr0  = instr == `LSBX_V_PMR0;
    assign is_pmw   = instr == `LSBX_V_PMW;
    assign is_in    = (instr & `LSBX_M_IO) == `LSBX_V_IN;
    assign is_out   = (instr & `LSBX_M_IO) == `LSBX_V_OUT;
    assign is_bset  = (instr & `LSBX_M_BSET) == `LSBX_V_BSET;
    assign is_br    = (instr & `LSBX_M_BR) == `LSBX_V_BR;
    assign is_store = instr[`LSBX_B_STORE];

    // Only T-clear, V and I branches belong to this unit
    assign br_ok = is_br && ((bsel == `LSBX_FLAG_T && instr[`LSBX_B_BRCLR])
                             || bsel == `LSBX_FLAG_V || bsel == `LSBX_FLAG_I);
    // Flags are sampled only, there is no path that writes them
    assign br_taken = instr[`LSBX_B_BRCLR] ? !sreg[bsel] : sreg[bsel];

    always_comb begin
        unique case (mode)
            4'h0, 4'h1, 4'h2, 4'h9, 4'hA, 4'hC, 4'hD, 4'hE, 4'hF: ldst_ok = 1'b1;
            4'h4, 4'h5: ldst_ok = !is_store;
            default:    ldst_ok = 1'b0;
        endcase
    end

    // Register view with a pending port read already folded in
    always_comb begin
        rfv = s_r.rf;
        if (s_r.in_pend) begin
            rfv[s_r.in_dst] = io_rdata;
        end
    end

    lsbx_agu u_agu (
        .instr     (instr),
        .instr_ext (instr_ext),
        .ptr_x     ({rfv[`LSBX_IDX_X + 5'h01], rfv[`LSBX_IDX_X]}),
        .ptr_y     ({rfv[`LSBX_IDX_Y + 5'h01], rfv[`LSBX_IDX_Y]}),
        .ptr_z     ({rfv[`LSBX_IDX_Z + 5'h01], rfv[`LSBX_IDX_Z]}),
        .sp        (s_r.sp),
        .agu       (agu)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        s_nxt          = s_r;
        s_nxt.rf       = rfv;
        s_nxt.done     = 1'b0;
        s_nxt.illegal  = 1'b0;
        s_nxt.in_pend  = 1'b0;
        s_nxt.dm.re    = 1'b0;
        s_nxt.dm.we    = 1'b0;
        s_nxt.pm.re    = 1'b0;
        s_nxt.pm.we    = 1'b0;
        s_nxt.io.re    = 1'b0;
        s_nxt.io.we    = 1'b0;
        unique case (s_r.state)
            SM_IDLE: begin
                if (acc) begin
                    s_nxt.pc         = s_r.pc + 16'h0001;
                    s_nxt.fetch_pend = 1'b0;
                    s_nxt.state      = SM_LAST;
                    s_nxt.ready      = 1'b0;
                    if (is_br && br_ok) begin
                        if (br_taken) begin
                            s_nxt.pc = s_r.pc + 16'h0001 + koff;
                        end else begin
                            s_nxt.state = SM_IDLE;
                        end
                    end else if (is_copy) begin
                        s_nxt.rf[fd] = rfv[fr];
                        s_nxt.state  = SM_IDLE;
                    end else if (is_pcopy) begin
                        s_nxt.rf[{instr[7:4], 1'b0}] = rfv[{instr[3:0], 1'b0}];
                        s_nxt.rf[{instr[7:4], 1'b1}] = rfv[{instr[3:0], 1'b1}];
                        s_nxt.state  = SM_IDLE;
                    end else if (is_imm) begin
                        s_nxt.rf[{1'b1, instr[7:4]}] = {instr[11:8], instr[3:0]};
                        s_nxt.state  = SM_IDLE;
                    end else if (is_in) begin
                        s_nxt.io.addr = {instr[10:9], instr[3:0]};
                        s_nxt.io.re   = 1'b1;
                        s_nxt.in_pend = 1'b1;
                        s_nxt.in_dst  = fd;
                        s_nxt.state   = SM_IDLE;
                    end else if (is_out) begin
                        s_nxt.io.addr  = {instr[10:9], instr[3:0]};
                        s_nxt.io.wdata = rfv[fd];
                        s_nxt.io.wmask = 8'hFF;
                        s_nxt.io.we    = 1'b1;
                        s_nxt.state    = SM_IDLE;
                    end else if (is_bset) begin
                        s_nxt.io.addr  = {1'b0, instr[7:3]};
                        s_nxt.io.wdata = 8'hFF;
                        s_nxt.io.wmask = 8'h01 << bsel;
                        s_nxt.io.we    = 1'b1;
                    end else if (is_pmw) begin
                        s_nxt.pm.addr  = {1'b0, rfv[`LSBX_IDX_Z + 5'h01], rfv[`LSBX_IDX_Z][7:1]};
                        s_nxt.pm.wdata = {rfv[`LSBX_IDX_R1], rfv[`LSBX_IDX_R0]};
                        s_nxt.pm.we    = 1'b1;
                    end else if (is_pmr0 || (is_ldst && !is_store
                                 && (mode == `LSBX_MD_PMR || mode == `LSBX_MD_PMRINC))) begin
                        s_nxt.pm.addr = {1'b0, rfv[`LSBX_IDX_Z + 5'h01], rfv[`LSBX_IDX_Z][7:1]};
                        s_nxt.pm.re   = 1'b1;
                        s_nxt.pm_odd  = rfv[`LSBX_IDX_Z][0];
                        s_nxt.dst     = is_pmr0 ? `LSBX_IDX_R0 : fd;
                        s_nxt.state   = SM_MEM;
                        if (!is_pmr0 && agu.ptr_we) begin
                            s_nxt.rf[agu.ptr_idx]        = agu.ptr_new[7:0];
                            s_nxt.rf[agu.ptr_idx + 5'h01] = agu.ptr_new[15:8];
                        end
                    end else if ((is_ldst && ldst_ok) || is_disp) begin
                        s_nxt.dm.addr = agu.ea;
                        s_nxt.dst     = fd;
                        if (is_ldst && mode == `LSBX_MD_DIRECT) begin
                            s_nxt.pc = s_r.pc + 16'h0002;
                        end
                        if (is_ldst && mode == `LSBX_MD_STACK) begin
                            s_nxt.sp = is_store ? s_r.sp - 16'h0001
                                                : s_r.sp + 16'h0001;
                        end
                        if (is_store) begin
                            s_nxt.dm.wdata = rfv[fd];
                            s_nxt.dm.we    = 1'b1;
                        end else begin
                            s_nxt.dm.re      = 1'b1;
                            s_nxt.fetch_pend = 1'b1;
                        end
                        if (agu.ptr_we) begin
                            s_nxt.rf[agu.ptr_idx]        = agu.ptr_new[7:0];
                            s_nxt.rf[agu.ptr_idx + 5'h01] = agu.ptr_new[15:8];
                        end
                    end else begin
                        s_nxt.illegal = 1'b1;
                        s_nxt.state   = SM_IDLE;
                    end
                    if (s_nxt.state == SM_IDLE) begin
                        s_nxt.ready = 1'b1;
                        s_nxt.done  = 1'b1;
                    end
                end
            end
            SM_MEM: begin
                s_nxt.rf[s_r.dst] = s_r.pm_odd ? pm_rdata[15:8] : pm_rdata[7:0];
                s_nxt.state       = SM_LAST;
            end
            SM_LAST: begin
                if (s_r.fetch_pend) begin
                    s_nxt.rf[s_r.dst] = dm_rdata;
                end
                s_nxt.fetch_pend = 1'b0;
                s_nxt.state      = SM_IDLE;
                s_nxt.ready   = 1'b1;
                s_nxt.done    = 1'b1;
            end
            default: begin
                s_nxt.state = SM_IDLE;
                s_nxt.ready = 1'b1;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s_r       <= '0;
            s_r.pc    <= PC_RESET;
            s_r.sp    <= SP_RESET;
            s_r.ready <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign instr_ready = s_r.ready;
    assign done        = s_r.done;
    assign illegal     = s_r.illegal;
    assign pc          = s_r.pc;
    assign sp          = s_r.sp;
    assign regs        = s_r.rf;
    assign dm          = s_r.dm;
    assign pm          = s_r.pm;
    assign io          = s_r.io;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    sequence seq_one;
        instr_ready && done;
    endsequence
    sequence seq_two;
        !instr_ready ##1 (instr_ready && done);
    endsequence
    sequence seq_three;
        !instr_ready [*2] ##1 (instr_ready && done);
    endsequence

    tclr_taken_a: assert property (acc && is_br && instr[10] && bsel == 3'h6 && !sreg[6]
        |=> (pc == $past(s_r.pc) + 16'h0001 + $past(koff)) ##0 seq_two)
        else $error("T-clear branch target or timing wrong");
    vset_skip_a: assert property (acc && is_br && !instr[10] && bsel == 3'h3 && !sreg[3]
        |=> seq_one ##0 (pc == $past(s_r.pc) + 16'h0001))
        else $error("Overflow-set branch not taken wrongly");
    vclr_taken_a: assert property (acc && is_br && instr[10] && bsel == 3'h3 && !sreg[3]
        |=> seq_two)
        else $error("Overflow-clear branch not two cycles");
    iset_skip_a: assert property (acc && is_br && !instr[10] && bsel == 3'h7 && !sreg[7]
        |=> seq_one)
        else $error("Irq-enabled branch fall-through not one cycle");
    iclr_taken_a: assert property (acc && is_br && instr[10] && bsel == 3'h7 && !sreg[7]
        |=> pc == $past(s_r.pc) + 16'h0001 + $past(koff))
        else $error("Irq-disabled branch target wrong");
    fetch_post_a: assert property (acc && is_ldst && !is_store && mode == 4'hD
        |=> dm.re && dm.addr == $past(agu.ptr_cur)
            && {regs[27], regs[26]} == $past(agu.ptr_cur) + 16'h0001 ##0 seq_two)
        else $error("Post-increment fetch wrong");
    fetch_pre_a: assert property (acc && is_ldst && ldst_ok && !is_store
        && mode[1:0] == 2'b10
        |=> dm.re && dm.addr == $past(agu.ptr_cur) - 16'h0001 ##1 done)
        else $error("Pre-decrement fetch wrong");
    fetch_disp_a: assert property (acc && is_disp && !is_store && fd < 5'h1C
        |=> dm.addr == $past(agu.ptr_cur) + {10'h000, $past(instr[13]),
            $past(instr[11:10]), $past(instr[2:0])} ##1 (regs[$past(fd, 2)] == $past(dm_rdata)))
        else $error("Displaced fetch wrong");
    fetch_direct_a: assert property (acc && is_ldst && !is_store && mode == 4'h0
        |=> dm.re && dm.addr == $past(instr_ext) && pc == $past(s_r.pc) + 16'h0002)
        else $error("Direct fetch wrong");
    write_post_a: assert property (acc && is_ldst && ldst_ok && is_store
        && mode[1:0] == 2'b01
        |=> dm.we && dm.addr == $past(agu.ptr_cur) && dm.wdata == $past(rfv[fd])
            ##0 seq_two)
        else $error("Post-increment write wrong");
    write_direct_a: assert property (acc && is_ldst && is_store && mode == 4'h0
        |=> dm.we && dm.addr == $past(instr_ext))
        else $error("Direct write wrong");
    pm_read_a: assert property (acc && is_pmr0 |=> pm.re ##0 seq_three)
        else $error("Program read not three cycles");
    push_sp_a: assert property (acc && is_ldst && is_store && mode == 4'hF
        |=> dm.we && dm.addr == $past(s_r.sp) && sp == $past(s_r.sp) - 16'h0001)
        else $error("Push wrong");
    io_bitset_a: assert property (acc && is_bset
        |=> io.we && io.wmask == (8'h01 << $past(bsel)) ##0 seq_two)
        else $error("I/O bit set wrong");
    single_cyc_a: assert property (acc && (is_copy || is_pcopy || is_imm || is_in || is_out)
        |=> seq_one)
        else $error("Single-cycle transfer took longer");

endmodule : lsbx_core

// [verilog/lsbx_consts.svh]
/*
 * Constants for the load/store/branch execution block: opcode masks and
 * match values, field positions, register indices and reset values.
 * Assumes 16-bit instruction words and a 32 x 8 working register file.
 */
// Operation
// - Branch when transfer flag clear, 1/2 cycles
// - Branch when overflow set, 1/2 cycles
// - Branch when overflow clear, 1/2 cycles
// - Branch when interrupts enabled, 1/2 cycles
// - Branch when interrupts disabled, 1/2 cycles
// - Indirect fetch then pointer increment, 2 cycles
// - Pointer decrement then indirect fetch, 2 cycles
// - Displaced fetch, pointer kept, 2 cycles
// - Direct fetch from instruction address, 2 cycles
// - Indirect write then pointer increment, 2 cycles
// - Pointer decrement then indirect write, 2 cycles
// - Displaced write, pointer kept, 2 cycles
// - Direct write to instruction address, 2 cycles
// - Program memory read via Z, 3 cycles
// - Push register on stack, 2 cycles
// - Pull register from stack, 2 cycles
// - Set one I/O register bit, 2 cycles
`ifndef LSBX_CONSTS_SVH
`define LSBX_CONSTS_SVH

// Opcode masks and match values
`define LSBX_M_COPY     16'hFC00
`define LSBX_V_COPY     16'h2C00
`define LSBX_M_PCOPY    16'hFF00
`define LSBX_V_PCOPY    16'h0100
`define LSBX_M_IMM      16'hF000
`define LSBX_V_IMM      16'hE000
`define LSBX_M_LDST     16'hFC00
`define LSBX_V_LDST     16'h9000
`define LSBX_M_DISP     16'hD000
`define LSBX_V_DISP     16'h8000
`define LSBX_V_PMR0     16'h95C8
`define LSBX_V_PMW      16'h95E8
`define LSBX_M_IO       16'hF800
`define LSBX_V_IN       16'hB000
`define LSBX_V_OUT      16'hB800
`define LSBX_M_BSET     16'hFF00
`define LSBX_V_BSET     16'h9A00
`define LSBX_M_BR       16'hF800
`define LSBX_V_BR       16'hF000

// Field positions
`define LSBX_B_STORE    9
`define LSBX_B_BRCLR    10
`define LSBX_B_DISPY    3

// Load/store group addressing modes
`define LSBX_MD_DIRECT  4'h0
`define LSBX_MD_PMR     4'h4
`define LSBX_MD_PMRINC  4'h5
`define LSBX_MD_STACK   4'hF
`define LSBX_AM_POST    2'b01
`define LSBX_AM_PRE     2'b10
`define LSBX_BS_X       2'b11
`define LSBX_BS_Y       2'b10

// Status flag positions
`define LSBX_FLAG_V     3'h3
`define LSBX_FLAG_T     3'h6
`define LSBX_FLAG_I     3'h7

// Register indices
`define LSBX_IDX_R0     5'h00
`define LSBX_IDX_R1     5'h01
`define LSBX_IDX_X      5'h1A
`define LSBX_IDX_Y      5'h1C
`define LSBX_IDX_Z      5'h1E

// Reset values
`define LSBX_PC_RESET   16'h0000
`define LSBX_SP_RESET   16'h045F

`endif

// [verilog/lsbx_pkg.sv]
/*
 * Types for the load/store/branch execution block.
 * Assumes memories answer in the cycle their strobe is high.
 */
package lsbx_pkg;

    typedef enum logic [1:0] {
        SM_IDLE = 2'b00,
        SM_MEM  = 2'b01,
        SM_LAST = 2'b10
    } lsbx_state_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        re;
        logic        we;
    } lsbx_dm_req_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic        re;
        logic        we;
    } lsbx_pm_req_t;

    typedef struct packed {
        logic [5:0]  addr;
        logic [7:0]  wdata;
        logic [7:0]  wmask;
        logic        re;
        logic        we;
    } lsbx_io_req_t;

    typedef struct packed {
        logic [15:0] ea;
        logic [15:0] ptr_cur;
        logic [15:0] ptr_new;
        logic [4:0]  ptr_idx;
        logic        ptr_we;
    } lsbx_agu_t;

    typedef struct packed {
        lsbx_state_t       state;
        logic [15:0]       pc;
        logic [15:0]       sp;
        logic [31:0][7:0]  rf;
        logic              ready;
        logic              done;
        logic              illegal;
        logic              fetch_pend;
        logic              pm_odd;
        logic [4:0]        dst;
        logic              in_pend;
        logic [4:0]        in_dst;
        lsbx_dm_req_t      dm;
        lsbx_pm_req_t      pm;
        lsbx_io_req_t      io;
    } lsbx_core_st_t;

endpackage : lsbx_pkg

// [verilog/lsbx_agu.sv]
/*
 * Address generation for indirect, displaced, direct and stack accesses.
 * Assumes the caller passes the pointer pairs with pending writes applied.
 */
`timescale 1ns/1ps
`include "lsbx_consts.svh"

module lsbx_agu
    import lsbx_pkg::*;
(
    input  wire logic [15:0] instr,
    input  wire logic [15:0] instr_ext,
    input  wire logic [15:0] ptr_x,
    input  wire logic [15:0] ptr_y,
    input  wire logic [15:0] ptr_z,
    input  wire logic [15:0] sp,
    output lsbx_agu_t        agu
);

    logic [3:0]  mode;
    logic [5:0]  disp;

    assign mode = instr[3:0];
    assign disp = {instr[13], instr[11:10], instr[2:0]};

    always_comb begin
        agu = '0;
        if ((instr & `LSBX_M_DISP) == `LSBX_V_DISP) begin
            agu.ptr_idx = instr[`LSBX_B_DISPY] ? `LSBX_IDX_Y : `LSBX_IDX_Z;
            agu.ptr_cur = instr[`LSBX_B_DISPY] ? ptr_y : ptr_z;
            agu.ea      = agu.ptr_cur + {10'h000, disp};
        end else if (mode == `LSBX_MD_DIRECT) begin
            agu.ea = instr_ext;
        end else if (mode == `LSBX_MD_STACK) begin
            agu.ea = instr[`LSBX_B_STORE] ? sp : sp + 16'h0001;
        end else begin
            unique case (mode[3:2])
                `LSBX_BS_X: begin
                    agu.ptr_idx = `LSBX_IDX_X;
                    agu.ptr_cur = ptr_x;
                end
                `LSBX_BS_Y: begin
                    agu.ptr_idx = `LSBX_IDX_Y;
                    agu.ptr_cur = ptr_y;
                end
                default: begin
                    agu.ptr_idx = `LSBX_IDX_Z;
                    agu.ptr_cur = ptr_z;
                end
            endcase
            agu.ea = agu.ptr_cur;
            if (mode[1:0] == `LSBX_AM_POST) begin
                agu.ptr_new = agu.ptr_cur + 16'h0001;
                agu.ptr_we  = 1'b1;
            end else if (mode[1:0] == `LSBX_AM_PRE) begin
                agu.ptr_new = agu.ptr_cur - 16'h0001;
                agu.ea      = agu.ptr_new;
                agu.ptr_we  = 1'b1;
            end
        end
    end

endmodule : lsbx_agu

// [verif/lsbx_mem_model.sv]
/*
 * Data, program and I/O memory model for the load/store/branch block.
 * Assumes strobes are one-cycle pulses; answers in the strobe cycle.
 */
`timescale 1ns/1ps

module lsbx_mem_model
    import lsbx_pkg::*;
(
    input  wire logic   mclk,
    input  lsbx_dm_req_t dm,
    input  lsbx_pm_req_t pm,
    input  lsbx_io_req_t io,
    output logic [7:0]  dm_rdata,
    output logic [15:0] pm_rdata,
    output logic [7:0]  io_rdata
);
    logic [7:0]  dmem [0:65535];
    logic [7:0]  iomem [0:63];
    logic [7:0]  dlast = 8'h00;
    logic [7:0]  ilast = 8'h00;
    logic [15:0] plast = 16'h0000;
    initial begin
        for (int i = 0; i < 65536; i++) dmem[i] = i[7:0] ^ 8'h3C;
        for (int i = 0; i < 64; i++) iomem[i] = 8'h00;
    end
    // Released read lines show the inverse of the last value
    assign dm_rdata = dm.re ? dmem[dm.addr] : ~dlast;
    assign pm_rdata = pm.re ? {~pm.addr[7:0], pm.addr[7:0]} : ~plast;
    assign io_rdata = io.re ? iomem[io.addr] : ~ilast;
    always @(posedge mclk) begin
        if (dm.we) dmem[dm.addr] <= dm.wdata;
        if (io.we) iomem[io.addr] <= (iomem[io.addr] & ~io.wmask) | (io.wdata & io.wmask);
        dlast <= dm_rdata;
        plast <= pm_rdata;
        ilast <= io_rdata;
    end
endmodule : lsbx_mem_model

// [verif/tb_load_store_branch_exec.sv]
/*
 * Self-checking bench for lsbx_core: driver queues notes, monitor checks
 * cycles, pc and results at each done pulse. Assumes lsbx_mem_model.
 */
`timescale 1ns/1ps

module tb_load_store_branch_exec
    import lsbx_pkg::*;
();
    typedef struct {int n; int kind; logic [15:0] pc; logic [15:0] a; logic [7:0] v;} lsbx_note_t;
    logic mclk = 0, rst = 1, instr_valid = 0, instr_ready, done, illegal;
    logic [15:0] instr = 16'h0000, instr_ext = 16'h0000, pm_rdata, pc, sp, pc_m = 16'h0000;
    logic [7:0] sreg = 8'h00, dm_rdata, io_rdata, v;
    logic [31:0][7:0] regs;
    lsbx_dm_req_t dm;
    lsbx_pm_req_t pm;
    lsbx_io_req_t io;
    lsbx_note_t q[$];
    int err_count = 0, samples_checked = 0, cyc = 0, t0 = 0;
    logic [15:0] bb [5] = '{16'hF406, 16'hF003, 16'hF403, 16'hF007, 16'hF407};
    int fb [5] = '{6, 3, 3, 7, 7};
    int wh [5] = '{0, 1, 0, 1, 0};

    always #12.5 mclk = ~mclk;

    lsbx_core u_dut (.mclk(mclk), .rst(rst), .instr_valid(instr_valid), .instr(instr),
        .instr_ext(instr_ext), .sreg(sreg), .dm_rdata(dm_rdata), .pm_rdata(pm_rdata),
        .io_rdata(io_rdata), .instr_ready(instr_ready), .done(done), .illegal(illegal),
        .pc(pc), .sp(sp), .regs(regs), .dm(dm), .pm(pm), .io(io));
    lsbx_mem_model u_mem (.mclk(mclk), .dm(dm), .pm(pm), .io(io), .dm_rdata(dm_rdata),
        .pm_rdata(pm_rdata), .io_rdata(io_rdata));

    task automatic chk(logic [15:0] got, logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic end_of_test();
        if (err_count == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_of_test

    // Offer one word, note expectation, wait until it is taken
    task automatic op(logic [15:0] i, logic [15:0] e, int n, logic [15:0] adv, int kind,
                      logic [15:0] a, logic [7:0] ev);
        logic ok;
        instr_valid = 1;
        instr = i;
        instr_ext = e;
        pc_m = pc_m + adv;
        q.push_back('{n, kind, pc_m, a, ev});
        do begin
            @(negedge mclk) ok = instr_ready;
            @(posedge mclk) #1;
        end while (ok !== 1'b1);
    endtask : op

    function automatic logic [15:0] imm_word(int d, logic [7:0] k);
        return 16'hE000 | {4'h0, k[7:4], 8'h00} | 16'((d - 16) << 4) | {12'h000, k[3:0]};
    endfunction : imm_word

    always @(negedge mclk) begin
        lsbx_note_t t;
        cyc++;
        if (cyc > 2000) begin
            err_count++;
            end_of_test();
        end
        if (done === 1'b1 && q.size() > 0) begin
            t = q.pop_front();
            chk(16'(cyc - t0), 16'(t.n));
            chk(pc, t.pc);
            chk({15'h0000, illegal}, {15'h0000, t.kind == 3});
            case (t.kind)
                0: chk({8'h00, regs[t.a[4:0]]}, {8'h00, t.v});
                1: chk({8'h00, u_mem.dmem[t.a]}, {8'h00, t.v});
                default: chk({8'h00, u_mem.iomem[t.a[5:0]]}, {8'h00, t.v});
            endcase
        end
        if (instr_valid && instr_ready) t0 = cyc;
    end

    initial begin
        logic [6:0] k;
        logic [15:0] ka;
        void'($urandom(50));
        repeat (3) @(posedge mclk);
        #1 rst = 0;
        for (int b = 0; b < 5; b++) begin
            for (int f = 0; f < 2; f++) begin
                k = 7'($urandom);
                sreg = 8'($urandom);
                sreg[fb[b]] = f[0];
                if (f == wh[b]) op(bb[b] | {6'h00, k, 3'h0}, 0, 2, 16'd1 + {{9{k[6]}}, k}, 0, 0, 0);
                else op(bb[b] | {6'h00, k, 3'h0}, 0, 1, 1, 0, 0, 0);
            end
        end
        op(imm_word(26, 8'h00), 0, 1, 1, 0, 26, 8'h00);
        op(imm_word(27, 8'h01), 0, 1, 1, 0, 27, 8'h01);
        op(imm_word(29, 8'h02), 0, 1, 1, 0, 29, 8'h02);
        op(imm_word(30, 8'h13), 0, 1, 1, 0, 30, 8'h13);
        op(16'h910D, 0, 2, 1, 0, 16, 8'h3C);
        op(16'h930D, 0, 2, 1, 1, 16'h0101, 8'h3C);
        op(16'h911E, 0, 2, 1, 0, 17, 8'h3C);
        op(16'h812D, 0, 2, 1, 0, 18, 8'h39);
        op(16'h9145, 0, 3, 1, 0, 20, 8'hF6);
        op(16'h95C8, 0, 3, 1, 0, 0, 8'h0A);
        ka = 16'h0300 | 16'($urandom % 256);
        v = ka[7:0] ^ 8'h3C;
        op(16'h9150, ka, 2, 2, 0, 21, v);
        op(16'h9350, ka ^ 16'h0080, 2, 2, 1, ka ^ 16'h0080, v);
        op(16'h935F, 0, 2, 1, 1, 16'h045F, v);
        op(16'h916F, 0, 2, 1, 0, 22, v);
        op(16'h2F76, 0, 1, 1, 0, 23, v);
        op(16'h9A2B, 0, 2, 1, 2, 5, 8'h08);
        // Port write, read back, then pair copy shows the port value
        op(16'hB971, 0, 1, 1, 0, 23, v);
        op(16'hB181, 0, 1, 1, 0, 23, v);
        op(16'h01DC, 0, 1, 1, 0, 26, v);
        op(16'h95E8, 0, 2, 1, 0, 26, v);
        op(16'hF001, 0, 1, 1, 3, 5, 8'h08);
        instr_valid = 0;
        repeat (5) @(posedge mclk);
        chk(16'(q.size()), 16'h0000);
        chk(sp, 16'h045F);
        end_of_test();
    end
endmodule : tb_load_store_branch_exec
